// ===== bench/obm_slv_model.sv
// Behavioural model of the six slaves behind the bus matrix
`timescale 1ns/1ps
module obm_slv_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [5:0] i_req,
  input obm_pkg::obm_word_t [5:0] i_addr,
  input wire logic [5:0] i_slow,
  output logic [5:0] o_ack,
  output obm_pkg::obm_word_t [5:0] o_rdata
);
  import obm_pkg::*;
  // ****************************************
  // Acknowledge timing
  // ****************************************
  // A slow slave waits seven cycles so buffered writes stay pending for a while
  logic [3:0] wait_cnt [6];
  always_ff @(posedge i_clk) begin
    for (int s = 0; s < 6; s++) begin
      if (i_srst) begin
        o_ack[s] <= 1'b0;
        wait_cnt[s] <= 4'h0;
      end else if (i_req[s] && !o_ack[s] && (!i_slow[s] || wait_cnt[s] == 4'h6)) begin
        o_ack[s] <= 1'b1;
        wait_cnt[s] <= 4'h0;
      end else begin
        o_ack[s] <= 1'b0;
        wait_cnt[s] <= (i_req[s] && !o_ack[s]) ? wait_cnt[s] + 4'h1 : 4'h0;
      end
    end
  end
  // Outside the ack cycle the data is inverted so a late sample cannot match
  always_comb begin
    for (int s = 0; s < 6; s++) begin
      o_rdata[s] = o_ack[s] ? (i_addr[s] ^ 32'h5a5a_a5a5) : ~(i_addr[s] ^ 32'h5a5a_a5a5);
    end
  end
endmodule

// ===== bench/tb.sv
// Self-checking testbench of the bus matrix
`timescale 1ns/1ps
`include "obm_consts.svh"
module tb;
  import obm_pkg::*;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [2:0] mst_req = '0;
  obm_word_t [2:0] mst_addr = '0;
  logic [2:0] mst_wr = '0;
  obm_word_t [2:0] mst_wdata = '0;
  logic [2:0] mst_ack;
  logic [2:0] mst_err;
  obm_word_t [2:0] mst_rdata;
  logic atomic_exchange_instr = 1'b0;
  logic info = 1'b0;
  logic tc_act = 1'b0;
  logic [5:0] slv_req;
  logic [5:0] slv_ack;
  logic [5:0] slow = '0;
  obm_word_t [5:0] slv_addr;
  obm_word_t [5:0] slv_rdata;
  logic [5:0] slv_wr;
  obm_word_t [5:0] slv_wdata;
  obm_word_t reg_addr = '0;
  obm_word_t reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  obm_word_t reg_rdata;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int ack_cyc [3];
  int sack_cyc [6];
  logic [5:0] slv_seen;
  obm_word_t map_addr [12];

  always #50 i_clk = ~i_clk;

  obm_matrix obm_matrix_i (
    .i_clk(i_clk), .i_srst(i_srst), .i_mst_req(mst_req), .i_mst_addr(mst_addr),
    .i_mst_wr(mst_wr), .i_mst_wdata(mst_wdata), .o_mst_ack(mst_ack), .o_mst_err(mst_err),
    .o_mst_rdata(mst_rdata), .i_atomic_exchange_instr_busy(atomic_exchange_instr), .i_tc_info_busy(info), .i_tc_active(tc_act),
    .o_slv_req(slv_req), .o_slv_wr(slv_wr), .o_slv_addr(slv_addr), .o_slv_wdata(slv_wdata),
    .i_slv_ack(slv_ack), .i_slv_rdata(slv_rdata), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata)
  );
  obm_slv_model obm_slv_model_i (
    .i_clk(i_clk), .i_srst(i_srst), .i_req(slv_req), .i_addr(slv_addr), .i_slow(slow),
    .o_ack(slv_ack), .o_rdata(slv_rdata)
  );

  // ****************************************
  // Monitor and helpers
  // ****************************************
  // Sampled mid-cycle so the records are settled before the tasks read them at an edge
  always @(negedge i_clk) begin
    cyc++;
    slv_seen = slv_seen | slv_req;
    for (int m = 0; m < 3; m++) if (mst_ack[m] === 1'b1) ack_cyc[m] = cyc;
    for (int s = 0; s < 6; s++) if (slv_ack[s] === 1'b1) sack_cyc[s] = cyc;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic clr;
    slv_seen = '0;
    for (int m = 0; m < 3; m++) ack_cyc[m] = 0;
    for (int s = 0; s < 6; s++) sack_cyc[s] = 0;
  endtask

  // One aligned word inside one area, never across a boundary
  task automatic access(input int m, input obm_word_t a, input logic w, input logic e);
    int n;
    n = 0;
    @(posedge i_clk);
    mst_req[m] <= 1'b1;
    mst_addr[m] <= a;
    mst_wr[m] <= w;
    mst_wdata[m] <= ~a;
    do begin
      @(posedge i_clk);
      n++;
    end while (mst_ack[m] !== 1'b1 && n < 60);
    mst_req[m] <= 1'b0;
    check(n < 60, 1'b1);
    check(mst_err[m], e);
    if (!w && !e) check(mst_rdata[m], a ^ 32'h5a5a_a5a5);
  endtask

  task automatic reg_write(input obm_word_t a, input obm_word_t d);
    @(posedge i_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge i_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input obm_word_t a, input obm_word_t exp);
    @(posedge i_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    @(posedge i_clk);
    check(reg_rdata, exp);
  endtask

  task automatic end_of_test;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles; allow about a hundred times that
  initial begin
    #3_000_000;
    bad_count++;
    end_of_test();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    // Same order as the slave channel numbers, two boundary words each
    map_addr = '{`OBM_RAM_LO, `OBM_RAM_HI - 32'h3, `OBM_ROM_LO, `OBM_ROM_HI - 32'h3,
                 `OBM_PB1_LO, `OBM_PB1_HI - 32'h3, `OBM_PB2_LO, `OBM_PB2_HI - 32'h3,
                 `OBM_PB3_LO, `OBM_PB3_HI - 32'h3, `OBM_PB6_LO, `OBM_PB6_HI - 32'h3};
    clr();
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    @(posedge i_clk);
    check(mst_ack, 3'h0);
    check(slv_req, 6'h00);
    reg_read(`OBM_REG_PRIO, 32'h0);
    $display("test reset done");

    for (int i = 0; i < 12; i++) begin
      clr();
      access(1, map_addr[i], 1'b0, 1'b0);
      check(slv_seen, 6'h01 << (i / 2));
    end
    clr();
    access(1, 32'h0001_0000, 1'b0, 1'b1);
    access(1, 32'h000c_0000, 1'b0, 1'b1);
    access(0, 32'h8000_0000, 1'b0, 1'b1);
    access(1, `OBM_ROM_LO + 32'h10, 1'b1, 1'b1);
    check(slv_seen, 6'h00);
    access(0, `OBM_ROM_LO + 32'h10, 1'b0, 1'b0);
    $display("test address map done");

    clr();
    fork
      access(0, `OBM_PB1_LO + 32'h20, 1'b0, 1'b0);
      access(1, `OBM_PB1_LO + 32'h24, 1'b0, 1'b0);
    join
    check(ack_cyc[1] < ack_cyc[0], 1'b1);
    clr();
    fork
      access(0, `OBM_ROM_LO + 32'h40, 1'b0, 1'b0);
      access(1, `OBM_RAM_LO + 32'h40, 1'b0, 1'b0);
      access(2, `OBM_PB2_LO + 32'h40, 1'b0, 1'b0);
    join
    check(ack_cyc[0], ack_cyc[1]);
    check(ack_cyc[2] <= ack_cyc[1] + 2, 1'b1);
    $display("test parallel done");

    clr();
    fork
      access(0, `OBM_RAM_LO + 32'h80, 1'b0, 1'b0);
      access(1, `OBM_RAM_LO + 32'h84, 1'b0, 1'b0);
      access(2, `OBM_RAM_LO + 32'h88, 1'b0, 1'b0);
    join
    check(ack_cyc[2] < ack_cyc[1] && ack_cyc[1] < ack_cyc[0], 1'b1);
    clr();
    fork
      access(1, `OBM_PB2_LO + 32'h80, 1'b0, 1'b0);
      access(2, `OBM_PB2_LO + 32'h84, 1'b0, 1'b0);
    join
    check(ack_cyc[2] < ack_cyc[1], 1'b1);
    $display("test fixed priority done");

    atomic_exchange_instr <= 1'b1;
    clr();
    fork
      access(2, `OBM_RAM_LO + 32'h100, 1'b0, 1'b0);
      access(1, `OBM_RAM_LO + 32'h104, 1'b0, 1'b0);
    join_none
    repeat (10) @(posedge i_clk);
    check(ack_cyc[2], 0);
    check(ack_cyc[1] != 0, 1'b1);
    atomic_exchange_instr <= 1'b0;
    wait fork;
    info <= 1'b1;
    clr();
    fork
      access(1, `OBM_RAM_LO + 32'h108, 1'b0, 1'b0);
      access(2, `OBM_PB2_LO + 32'h108, 1'b0, 1'b0);
    join_none
    repeat (10) @(posedge i_clk);
    check(ack_cyc[1], 0);
    check(ack_cyc[2] != 0, 1'b1);
    info <= 1'b0;
    wait fork;
    $display("test locks done");

    slow <= 6'h08;
    clr();
    access(1, `OBM_PB2_LO + 32'h200, 1'b1, 1'b0);
    check(sack_cyc[3], 0);
    check(slv_wr[3], 1'b1);
    check(slv_wdata[3], ~(`OBM_PB2_LO + 32'h200));
    access(1, `OBM_PB1_LO + 32'h200, 1'b0, 1'b0);
    check(sack_cyc[3] != 0 && ack_cyc[1] > sack_cyc[3], 1'b1);
    clr();
    access(1, `OBM_PB2_LO + 32'h204, 1'b1, 1'b0);
    access(1, `OBM_RAM_LO + 32'h204, 1'b0, 1'b0);
    check(sack_cyc[3], 0);
    repeat (12) @(posedge i_clk);
    check(sack_cyc[3] != 0, 1'b1);
    slow <= 6'h00;
    $display("test write buffer done");

    tc_act <= 1'b1;
    reg_write(`OBM_REG_PRIO, 32'h0000_0451);
    reg_read(`OBM_REG_PRIO, 32'h0);
    tc_act <= 1'b0;
    reg_write(`OBM_REG_PRIO, 32'h0000_f451);
    reg_read(`OBM_REG_PRIO, 32'h0000_0451);
    reg_write(`OBM_REG_PRIO, 32'h0);
    reg_read(`OBM_REG_PRIO, 32'h0000_0451);
    reg_read(32'h0008_1318, 32'h0);
    // RAM and pb1 toggled, ROM left fixed
    for (int k = 0; k < 3; k++) begin
      map_addr[0] = (k == 0) ? `OBM_RAM_LO + 32'h300 : (k == 1) ? `OBM_PB1_LO + 32'h300
                                                               : `OBM_ROM_LO + 32'h300;
      access(2, map_addr[0], 1'b0, 1'b0);
      clr();
      fork
        access(1, map_addr[0] + 32'h4, 1'b0, 1'b0);
        access(2, map_addr[0] + 32'h8, 1'b0, 1'b0);
      join
      check(ack_cyc[1] < ack_cyc[2], k < 2);
    end
    $display("test toggled priority done");
    end_of_test();
  end
endmodule

// ===== rtl/obm_arb2.sv
// Two-requester arbiter with fixed or toggled priority
`timescale 1ns/1ps
module obm_arb2 (
  input wire logic i_clk,
  input wire logic i_srst,
  obm_arb_if.arb arb
);
  import obm_pkg::*;
  logic last_hi;
  logic next_last_hi;
  logic pref_lo;

  always_comb begin
    pref_lo = arb.mode_tgl & last_hi;
    arb.grant_hi = arb.free & arb.req_hi & (!arb.req_lo | !pref_lo);
    arb.grant_lo = arb.free & arb.req_lo & !arb.grant_hi;
    next_last_hi = last_hi;
    if (arb.grant_hi | arb.grant_lo) begin
      next_last_hi = arb.grant_hi;
    end
  end

  // Reset state prefers the high side, as fixed priority would
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      last_hi <= 1'b0;
    end else begin
      last_hi <= next_last_hi;
    end
  end

  assign arb.last_hi = last_hi;
endmodule

// ===== rtl/obm_chan.sv
// One slave channel: holds an accepted access until the slave acknowledges
`timescale 1ns/1ps
module obm_chan (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_take,
  input obm_pkg::obm_mst_t i_mst,
  input obm_pkg::obm_word_t i_addr,
  input wire logic i_wr,
  input obm_pkg::obm_word_t i_wdata,
  input wire logic i_ack,
  output logic o_busy,
  output logic o_done,
  output obm_pkg::obm_mst_t o_owner,
  output logic o_wr,
  output obm_pkg::obm_word_t o_addr,
  output obm_pkg::obm_word_t o_wdata
);
  import obm_pkg::*;
  obm_ch_state_t state;
  obm_ch_state_t next_state;
  obm_mst_t next_owner;
  logic next_wr;
  obm_word_t next_addr;
  obm_word_t next_wdata;

  always_comb begin
    next_state = state;
    next_owner = o_owner;
    next_wr = o_wr;
    next_addr = o_addr;
    next_wdata = o_wdata;
    unique case (state)
      OBM_CH_IDLE: begin
        if (i_take) begin
          next_state = OBM_CH_BUSY;
          next_owner = i_mst;
          next_wr = i_wr;
          next_addr = i_addr;
          next_wdata = i_wdata;
        end
      end
      OBM_CH_BUSY: begin
        if (i_ack) begin
          next_state = OBM_CH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= OBM_CH_IDLE;
      o_owner <= '0;
      o_wr <= 1'b0;
      o_addr <= '0;
      o_wdata <= '0;
    end else begin
      state <= next_state;
      o_owner <= next_owner;
      o_wr <= next_wr;
      o_addr <= next_addr;
      o_wdata <= next_wdata;
    end
  end

  assign o_busy = (state == OBM_CH_BUSY);
  assign o_done = o_busy & i_ack;
endmodule

// ===== rtl/obm_matrix.sv
// Bus matrix: decode, per-slave arbitration, locks and write buffering
`timescale 1ns/1ps
`include "obm_consts.svh"

// How it works
// - Low 64K addresses go to RAM bus
// - 0008_0000-0008_7FFF go to peripheral bus 1
// - 0008_8000-0009_FFFF go to peripheral bus 2
// - 000A_0000-000B_FFFF go to peripheral bus 3
// - 0010_0000-00FF_FFFF go to peripheral bus 6
// - FF00_0000 upward is read-only ROM bus
// - ROM writes refused; programming uses peripheral bus
// - Operand beats instruction fetch on main bus 1
// - Fetch and operand to different memories run together
// - Fixed memory priority: controller, operand, fetch
// - Toggled memory priority demotes the last winner
// - Fixed peripheral priority: main bus 2 first
// - Toggled peripheral priority demotes the last winner
// - Five independent priority selections
// - Atomic exchange locks out the transfer controller
// - Descriptor access locks out the CPU
// - Transfer controller outranks CPU on main bus 2
// - Peripheral writes are buffered and acknowledged early
// - Switching peripheral bus waits for buffered writes
// - Memory reads may pass a buffered peripheral write
// - Different masters to different slaves run in parallel, except fetch and operand both to peripheral buses
// - Code 00 fixed, 01 toggled; written once
module obm_matrix (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [2:0] i_mst_req,
  input obm_pkg::obm_word_t [2:0] i_mst_addr,
  input wire logic [2:0] i_mst_wr,
  input obm_pkg::obm_word_t [2:0] i_mst_wdata,
  output logic [2:0] o_mst_ack,
  output logic [2:0] o_mst_err,
  output obm_pkg::obm_word_t [2:0] o_mst_rdata,
  input wire logic i_atomic_exchange_instr_busy,
  input wire logic i_tc_info_busy,
  input wire logic i_tc_active,
  output logic [5:0] o_slv_req,
  output logic [5:0] o_slv_wr,
  output obm_pkg::obm_word_t [5:0] o_slv_addr,
  output obm_pkg::obm_word_t [5:0] o_slv_wdata,
  input wire logic [5:0] i_slv_ack,
  input obm_pkg::obm_word_t [5:0] i_slv_rdata,
  input obm_pkg::obm_word_t i_reg_addr,
  input obm_pkg::obm_word_t i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output obm_pkg::obm_word_t o_reg_rdata
);
  import obm_pkg::*;
  // Channels behind the write buffer; a literal cannot be bit-selected
  localparam logic [5:0] PERIPH_MASK = `OBM_PB_MASK;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [5:0] decode(input obm_word_t a);
    decode = '0;
    if (a <= `OBM_RAM_HI) begin
      decode[`OBM_SL_RAM] = 1'b1;
    end else if (a >= `OBM_PB1_LO && a <= `OBM_PB1_HI) begin
      decode[`OBM_SL_PB1] = 1'b1;
    end else if (a >= `OBM_PB2_LO && a <= `OBM_PB2_HI) begin
      decode[`OBM_SL_PB2] = 1'b1;
    end else if (a >= `OBM_PB3_LO && a <= `OBM_PB3_HI) begin
      decode[`OBM_SL_PB3] = 1'b1;
    end else if (a >= `OBM_PB6_LO && a <= `OBM_PB6_HI) begin
      decode[`OBM_SL_PB6] = 1'b1;
    end else if (a >= `OBM_ROM_LO) begin
      decode[`OBM_SL_ROM] = 1'b1;
    end
  endfunction

  // Prohibited codes fall back to fixed priority
  function automatic logic toggled(input logic [15:0] pr, input int c);
    logic [3:0] lsb;
    case (c)
      0: lsb = `OBM_PRIO_RAM;
      1: lsb = `OBM_PRIO_ROM;
      2: lsb = `OBM_PRIO_PB1;
      3, 4: lsb = `OBM_PRIO_PB23;
      default: lsb = `OBM_PRIO_PB6;
    endcase
    toggled = (pr[lsb +: 2] == `OBM_MODE_TGL);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [2:0] outst;
  logic [2:0] next_outst;
  logic [2:0] next_ack;
  logic [2:0] next_err;
  obm_word_t [2:0] next_rdata;
  logic [15:0] prio;
  logic [15:0] next_prio;
  logic prio_done;
  logic next_prio_done;
  obm_word_t next_reg_rdata;

  logic [2:0][5:0] dec;
  logic [2:0][5:0] want;
  logic [2:0][5:0] pend;
  logic [2:0] eff;
  logic [2:0] wr_eff;
  logic [2:0] bad;
  logic [2:0] stall;
  logic [2:0] new_take;
  logic [5:0] lo_want;
  obm_mst_t [5:0] lo_mst;
  obm_mst_t mb1;
  logic [5:0] take;
  obm_mst_t [5:0] win;
  logic [5:0] busy;
  logic [5:0] done;
  logic [5:0] tgl_st;
  obm_mst_t [5:0] owner;

  // ****************************************
  // Request qualification
  // ****************************************
  always_comb begin
    want = '0;
    pend = '0;
    for (int m = 0; m < 3; m++) begin
      dec[m] = decode(i_mst_addr[m]);
      wr_eff[m] = i_mst_wr[m] & (m != `OBM_M_IF);
      eff[m] = i_mst_req[m] & !outst[m] &
               ((m == `OBM_M_TC) ? !i_atomic_exchange_instr_busy : !i_tc_info_busy);
      bad[m] = (dec[m] == '0) | (dec[m][`OBM_SL_ROM] & wr_eff[m]);
      for (int c = 0; c < 6; c++) begin
        pend[m][c] = busy[c] & o_slv_wr[c] & (owner[c] == m[1:0]) & PERIPH_MASK[c];
      end
      // Memory targets are never held back by a buffered peripheral write
      stall[m] = |(dec[m] & `OBM_PB_MASK) & |(pend[m] & ~dec[m]);
      want[m] = (eff[m] & !bad[m] & !stall[m]) ? dec[m] : '0;
    end
    mb1 = |(want[`OBM_M_OP] & `OBM_PB_MASK) ? `OBM_M_OP : `OBM_M_IF;
    for (int c = 0; c < 6; c++) begin
      if (PERIPH_MASK[c]) begin
        lo_want[c] = want[mb1][c];
        lo_mst[c] = mb1;
      end else begin
        lo_want[c] = want[`OBM_M_OP][c] | want[`OBM_M_IF][c];
        lo_mst[c] = want[`OBM_M_OP][c] ? `OBM_M_OP : `OBM_M_IF;
      end
    end
  end

  // ****************************************
  // Arbitration points and slave channels
  // ****************************************
  for (genvar gc = 0; gc < 6; gc++) begin : g_pt
    obm_arb_if aif();
    assign aif.mode_tgl = toggled(prio, gc);
    assign aif.free = !busy[gc];
    assign aif.req_hi = want[`OBM_M_TC][gc];
    assign aif.req_lo = lo_want[gc];
    assign take[gc] = aif.grant_hi | aif.grant_lo;
    assign win[gc] = aif.grant_hi ? `OBM_M_TC : lo_mst[gc];
    assign tgl_st[gc] = aif.last_hi;
    obm_arb2 u_arb (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .arb(aif.arb)
    );
    obm_chan u_chan (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_take(take[gc]),
      .i_mst(win[gc]),
      .i_addr(i_mst_addr[win[gc]]),
      .i_wr(wr_eff[win[gc]]),
      .i_wdata(i_mst_wdata[win[gc]]),
      .i_ack(i_slv_ack[gc]),
      .o_busy(busy[gc]),
      .o_done(done[gc]),
      .o_owner(owner[gc]),
      .o_wr(o_slv_wr[gc]),
      .o_addr(o_slv_addr[gc]),
      .o_wdata(o_slv_wdata[gc])
    );
  end
  assign o_slv_req = busy;

  // ****************************************
  // Master answers
  // ****************************************
  always_comb begin
    next_outst = outst;
    next_ack = '0;
    next_err = '0;
    next_rdata = o_mst_rdata;
    for (int m = 0; m < 3; m++) begin
      new_take[m] = 1'b0;
      if (o_mst_ack[m]) begin
        next_outst[m] = 1'b0;
      end
      if (eff[m] & bad[m]) begin
        next_outst[m] = 1'b1;
        next_ack[m] = 1'b1;
        next_err[m] = 1'b1;
      end
      for (int c = 0; c < 6; c++) begin
        if (take[c] && win[c] == m[1:0]) begin
          new_take[m] = 1'b1;
          next_outst[m] = 1'b1;
          if (wr_eff[m] && PERIPH_MASK[c]) begin
            next_ack[m] = 1'b1;
          end
        end
        if (done[c] && owner[c] == m[1:0] && !(o_slv_wr[c] && PERIPH_MASK[c])) begin
          next_ack[m] = 1'b1;
          next_rdata[m] = i_slv_rdata[c];
        end
      end
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  // Selections lock after the first write so arbitration never shifts mid-run
  always_comb begin
    next_prio = prio;
    next_prio_done = prio_done;
    next_reg_rdata = '0;
    if (i_reg_wr && i_reg_addr == `OBM_REG_PRIO && !prio_done && !i_tc_active) begin
      next_prio = i_reg_wdata[15:0] & `OBM_PRIO_MASK;
      next_prio_done = 1'b1;
    end
    if (i_reg_rd && i_reg_addr == `OBM_REG_PRIO) begin
      next_reg_rdata = {16'h0000, prio};
    end else if (i_reg_rd && i_reg_addr == `OBM_REG_STAT) begin
      next_reg_rdata = {18'h00000, busy, 2'h0, tgl_st};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      outst <= '0;
      o_mst_ack <= '0;
      o_mst_err <= '0;
      o_mst_rdata <= '0;
      prio <= '0;
      prio_done <= 1'b0;
      o_reg_rdata <= '0;
    end else begin
      outst <= next_outst;
      o_mst_ack <= next_ack;
      o_mst_err <= next_err;
      o_mst_rdata <= next_rdata;
      prio <= next_prio;
      prio_done <= next_prio_done;
      o_reg_rdata <= next_reg_rdata;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_ram_range: assert property (@(posedge i_clk) disable iff (i_srst)
    o_slv_req[`OBM_SL_RAM] |-> o_slv_addr[`OBM_SL_RAM] <= `OBM_RAM_HI)
    else $error("RAM bus got an address outside its range");
  a_pb1_range: assert property (@(posedge i_clk) disable iff (i_srst)
    take[`OBM_SL_PB1] |=> o_slv_addr[`OBM_SL_PB1] >= `OBM_PB1_LO &&
      o_slv_addr[`OBM_SL_PB1] <= `OBM_PB1_HI)
    else $error("Peripheral bus 1 got a foreign address");
  a_pb2_range: assert property (@(posedge i_clk) disable iff (i_srst)
    o_slv_req[`OBM_SL_PB2] |-> o_slv_addr[`OBM_SL_PB2] >= `OBM_PB2_LO &&
      o_slv_addr[`OBM_SL_PB2] <= `OBM_PB2_HI)
    else $error("Peripheral bus 2 got a foreign address");
  a_pb3_range: assert property (@(posedge i_clk) disable iff (i_srst)
    o_slv_req[`OBM_SL_PB3] |-> o_slv_addr[`OBM_SL_PB3] >= `OBM_PB3_LO &&
      o_slv_addr[`OBM_SL_PB3] <= `OBM_PB3_HI)
    else $error("Peripheral bus 3 got a foreign address");
  a_pb6_range: assert property (@(posedge i_clk) disable iff (i_srst)
    o_slv_req[`OBM_SL_PB6] |-> o_slv_addr[`OBM_SL_PB6] >= `OBM_PB6_LO &&
      o_slv_addr[`OBM_SL_PB6] <= `OBM_PB6_HI)
    else $error("Peripheral bus 6 got a foreign address");
  a_rom_read_only: assert property (@(posedge i_clk) disable iff (i_srst)
    o_slv_req[`OBM_SL_ROM] |-> !o_slv_wr[`OBM_SL_ROM] &&
      o_slv_addr[`OBM_SL_ROM] >= `OBM_ROM_LO)
    else $error("ROM bus saw a write or a foreign address");
  a_rom_wr_err: assert property (@(posedge i_clk) disable iff (i_srst)
    eff[`OBM_M_OP] && i_mst_wr[`OBM_M_OP] && dec[`OBM_M_OP][`OBM_SL_ROM]
      |=> o_mst_ack[`OBM_M_OP] && o_mst_err[`OBM_M_OP])
    else $error("Operand write to ROM was not refused");
  a_op_first: assert property (@(posedge i_clk) disable iff (i_srst)
    take[`OBM_SL_PB1] && win[`OBM_SL_PB1] == `OBM_M_IF |-> !want[`OBM_M_OP][`OBM_SL_PB1])
    else $error("Fetch took peripheral bus 1 over a waiting operand");
  a_fixed_mem: assert property (@(posedge i_clk) disable iff (i_srst)
    !toggled(prio, 0) && want[`OBM_M_TC][`OBM_SL_RAM] && !busy[`OBM_SL_RAM]
      |-> take[`OBM_SL_RAM] && win[`OBM_SL_RAM] == `OBM_M_TC)
    else $error("Fixed RAM arbitration did not favour main bus 2");
  a_atomic_exchange_instr_lock: assert property (@(posedge i_clk) disable iff (i_srst)
    i_atomic_exchange_instr_busy |-> !new_take[`OBM_M_TC])
    else $error("Transfer controller granted during atomic exchange");
  a_info_lock: assert property (@(posedge i_clk) disable iff (i_srst)
    i_tc_info_busy |-> !new_take[`OBM_M_OP] && !new_take[`OBM_M_IF])
    else $error("CPU granted during descriptor access");
  a_wbuf_ack: assert property (@(posedge i_clk) disable iff (i_srst)
    take[`OBM_SL_PB2] && wr_eff[win[`OBM_SL_PB2]] |=> o_mst_ack[owner[`OBM_SL_PB2]])
    else $error("Buffered peripheral write was not acknowledged early");
  a_slv_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    o_slv_req[`OBM_SL_PB2] && !i_slv_ack[`OBM_SL_PB2]
      |=> o_slv_req[`OBM_SL_PB2] && $stable(o_slv_addr[`OBM_SL_PB2]))
    else $error("Peripheral bus 2 dropped or changed an unfinished access");
  a_pb_switch: assert property (@(posedge i_clk) disable iff (i_srst)
    pend[`OBM_M_OP][`OBM_SL_PB2] |-> !(take[`OBM_SL_PB3] && win[`OBM_SL_PB3] == `OBM_M_OP))
    else $error("Operand moved to another peripheral bus past its buffered write");
  a_split_fetch: assert property (@(posedge i_clk) disable iff (i_srst)
    want[`OBM_M_OP][`OBM_SL_RAM] && want[`OBM_M_IF][`OBM_SL_ROM] && !busy[`OBM_SL_RAM] &&
      !busy[`OBM_SL_ROM] && !want[`OBM_M_TC][`OBM_SL_RAM] && !want[`OBM_M_TC][`OBM_SL_ROM]
      |-> take[`OBM_SL_RAM] && take[`OBM_SL_ROM])
    else $error("Fetch and operand to different memories did not start together");
  a_tgl_mem: assert property (@(posedge i_clk) disable iff (i_srst)
    toggled(prio, 0) && tgl_st[`OBM_SL_RAM] && lo_want[`OBM_SL_RAM] && !busy[`OBM_SL_RAM]
      |-> take[`OBM_SL_RAM] && win[`OBM_SL_RAM] != `OBM_M_TC)
    else $error("Toggled RAM arbitration kept the last winner on top");
  a_fixed_periph: assert property (@(posedge i_clk) disable iff (i_srst)
    !toggled(prio, 3) && want[`OBM_M_TC][`OBM_SL_PB2] && !busy[`OBM_SL_PB2]
      |-> take[`OBM_SL_PB2] && win[`OBM_SL_PB2] == `OBM_M_TC)
    else $error("Fixed peripheral arbitration did not favour main bus 2");
  a_tgl_periph: assert property (@(posedge i_clk) disable iff (i_srst)
    toggled(prio, 2) && tgl_st[`OBM_SL_PB1] && lo_want[`OBM_SL_PB1] && !busy[`OBM_SL_PB1]
      |-> take[`OBM_SL_PB1] && win[`OBM_SL_PB1] != `OBM_M_TC)
    else $error("Toggled peripheral arbitration kept the last winner on top");
  a_mem_pass: assert property (@(posedge i_clk) disable iff (i_srst)
    pend[`OBM_M_OP][`OBM_SL_PB2] && want[`OBM_M_OP][`OBM_SL_RAM] && !busy[`OBM_SL_RAM] &&
      !want[`OBM_M_TC][`OBM_SL_RAM] |-> take[`OBM_SL_RAM] && win[`OBM_SL_RAM] == `OBM_M_OP)
    else $error("Memory read waited behind a buffered peripheral write");
  a_par_masters: assert property (@(posedge i_clk) disable iff (i_srst)
    want[`OBM_M_TC][`OBM_SL_PB2] && want[`OBM_M_OP][`OBM_SL_RAM] && !busy[`OBM_SL_PB2] &&
      !busy[`OBM_SL_RAM] |-> take[`OBM_SL_PB2] && take[`OBM_SL_RAM])
    else $error("Controller and operand to different slaves did not run together");
  a_prio_once: assert property (@(posedge i_clk) disable iff (i_srst)
    prio_done && i_reg_wr |=> prio == $past(prio))
    else $error("Priority selections changed after the first write");
endmodule

// ===== shared/obm_arb_if.sv
// Link between the matrix and one two-way arbitration point
`timescale 1ns/1ps
interface obm_arb_if;
  logic mode_tgl;
  logic req_hi;
  logic req_lo;
  logic free;
  logic grant_hi;
  logic grant_lo;
  logic last_hi;
  modport arb (input mode_tgl, req_hi, req_lo, free, output grant_hi, grant_lo, last_hi);
  modport user (output mode_tgl, req_hi, req_lo, free, input grant_hi, grant_lo, last_hi);
endinterface

// ===== shared/obm_consts.svh
// Address map, register layout and codes of the bus matrix
`ifndef OBM_CONSTS_SVH
`define OBM_CONSTS_SVH
`define OBM_RAM_LO 32'h0000_0000
`define OBM_RAM_HI 32'h0000_ffff
`define OBM_PB1_LO 32'h0008_0000
`define OBM_PB1_HI 32'h0008_7fff
`define OBM_PB2_LO 32'h0008_8000
`define OBM_PB2_HI 32'h0009_ffff
`define OBM_PB3_LO 32'h000a_0000
`define OBM_PB3_HI 32'h000b_ffff
`define OBM_PB6_LO 32'h0010_0000
`define OBM_PB6_HI 32'h00ff_ffff
`define OBM_ROM_LO 32'hff00_0000
`define OBM_ROM_HI 32'hffff_ffff
`define OBM_SL_RAM 3'h0
`define OBM_SL_ROM 3'h1
`define OBM_SL_PB1 3'h2
`define OBM_SL_PB2 3'h3
`define OBM_SL_PB3 3'h4
`define OBM_SL_PB6 3'h5
`define OBM_PB_MASK 6'h3c
`define OBM_M_IF 2'h0
`define OBM_M_OP 2'h1
`define OBM_M_TC 2'h2
`define OBM_REG_PRIO 32'h0008_1310
`define OBM_REG_STAT 32'h0008_1314
`define OBM_PRIO_MASK 16'h0cff
`define OBM_PRIO_RAM 4'h0
`define OBM_PRIO_ROM 4'h2
`define OBM_PRIO_PB1 4'h4
`define OBM_PRIO_PB23 4'h6
`define OBM_PRIO_PB6 4'ha
`define OBM_MODE_TGL 2'h1
`define OBM_STAT_BUSY 4'h8
`endif

// ===== shared/obm_pkg.sv
// Types shared by the bus matrix modules
package obm_pkg;
  typedef logic [1:0] obm_mst_t;
  typedef logic [31:0] obm_word_t;
  typedef enum logic [1:0] {
    OBM_CH_IDLE = 2'b01,
    OBM_CH_BUSY = 2'b10
  } obm_ch_state_t;
endpackage
